// ### rtl/afa_pkg.sv
/*
 afa_pkg: constants, ops and carriers for the flag and data-address block.
 assumes: one 100 MHz core clock, APB register access.
*/
package afa_pkg;
    // flag bit positions
    localparam int FLG_C = 0;
    localparam int FLG_DC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_N = 4;
    localparam logic [4:0] FLG_RST = 5'h00;
    localparam logic [4:0] FLG_ALL = 5'h1f;
    // direct addressing
    localparam logic [7:0] ACC_SPLIT = 8'h60;
    localparam logic [7:0] ILO_LIMIT = 8'h5f;
    localparam logic [3:0] ACC_LO_BANK = 4'h0;
    localparam logic [3:0] ACC_HI_BANK = 4'hf;
    // data-space locations
    localparam logic [11:0] FLAG_ADDR = 12'hfd8;
    localparam logic [11:0] VIRT_BASE = 12'hfef;
    localparam int VIRT_STRIDE = 8;
    // virtual operand slots below each pointer base
    localparam logic [2:0] VS_VIRTUAL_INDIRECT_OPERAND = 3'h0;
    localparam logic [2:0] VS_POST_INCREMENT_OPERAND = 3'h1;
    localparam logic [2:0] VS_POST_DECREMENT_OPERAND = 3'h2;
    localparam logic [2:0] VS_PRE_INCREMENT_OPERAND = 3'h3;
    localparam logic [2:0] VS_INDEXED_BY_WORKING_OPERAND = 3'h4;
    localparam int NUM_PTR = 3;
    // apb register byte offsets
    localparam logic [7:0] OFS_FLAGS = 8'h00;
    localparam logic [7:0] OFS_BANK = 8'h04;
    localparam logic [7:0] OFS_PTR0 = 8'h08;
    localparam logic [7:0] OFS_CFG = 8'h14;
    localparam logic [7:0] OFS_STEP = 8'h04;

    typedef enum logic [3:0] {
        OP_MOVE, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR,
        OP_CLR, OP_RLC, OP_RRC, OP_JUMP
    } afa_op_t;

    typedef struct packed {
        logic valid;
        afa_op_t op;
        logic [7:0] fileData;
        logic [7:0] work;
        logic [7:0] fileAddr;
        logic accessSel;
        logic destSel;
        logic fullMode;
        logic [11:0] fullAddr;
        logic [19:0] jumpLit;
    } afa_req_t;

    typedef struct packed {
        logic valid;
        logic [11:0] dataAddr;
        logic [7:0] result;
        logic fileWrite;
        logic workWrite;
        logic indirect;
        logic [19:0] jumpTarget;
    } afa_rsp_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } afa_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } afa_apb_rsp_t;
endpackage : afa_pkg

// ### rtl/afa_core.sv
/*
 afa_core: alu flag register and data address generation.
 assumes: decoder presents one request per cycle with operand data
 already fetched; memory acts on the registered answer.
*/
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Overview of operation
// - flag-affecting ops to flag register keep alu flags
// - clear of flag register sets only zero
// - negative flag follows result bit seven
// - overflow flag on signed sign-bit corruption
// - zero flag set on zero result
// - nibble carry from low nibble on add/sub
// - carry out of bit seven on add/sub
// - subtract adds complement; carries mean no borrow
// - rotates load carry and nibble carry
// - direct address from opcode low byte
// - access-select set uses bank select value
// - access-select clear maps into access bank
// - full twelve-bit opcode address ignores bank
// - destination bit picks file or working
// - three twelve-bit pointer pairs, two bytes each
// - virtual operands reach pointed memory only
// - indirect uses full pointer, ignores bank
// - jump carries twenty-bit program literal
// - indexed literal offset only with extended bit
// - post/pre adjust and working-indexed offset
// - pointer adjust carries across bytes, no flags
////////////////////////////////////////////////////////////////////////
module afa_core
    import afa_pkg::*;
(
    input wire logic sys_clk, // core clock
    input wire logic sys_rst, // sync reset, high
    input wire afa_pkg::afa_req_t req, // decoder request
    output afa_pkg::afa_rsp_t rsp, // registered answer
    output logic [7:0] flagsOut, // flag register view
    input wire afa_pkg::afa_apb_req_t apbReq, // apb request
    output afa_pkg::afa_apb_rsp_t apbRsp // apb answer
);
    import afa_pkg::*;

    // whole block state
    typedef struct packed {
        logic [4:0] flags; // n ov z dc c
        logic [3:0] bank; // bank select value
        logic [NUM_PTR-1:0][11:0] ptr; // pointer pairs
        logic extCfg; // extended set config bit
        afa_rsp_t rsp; // answer register
        logic [31:0] prdata; // read data
        logic slverr; // unmapped access
    } afa_state_t;

    afa_state_t st_reg; // current state
    afa_state_t st_next; // next state

    logic [11:0] directAddr; // address before virtual check
    logic [11:0] effAddr; // final data address
    logic vHit; // virtual operand selected
    logic [1:0] vPtr; // pointer index
    logic [2:0] vSlot; // operand kind
    logic [11:0] curPtr; // selected pointer value
    logic [11:0] usePtr; // pointer as used
    logic [11:0] newPtr; // pointer after adjust
    logic [7:0] aluRes; // alu result
    logic [4:0] aluNew; // flags from alu
    logic [4:0] aluMask; // flags the op touches
    logic [8:0] sum9; // full sum with carry
    logic [4:0] sum5; // low nibble sum
    logic [7:0] opB; // second operand, maybe inverted
    logic cin; // carry in for subtract
    logic fileWr; // result goes to file
    logic apbSetup; // apb setup cycle
    logic apbWrite; // apb write completes

    ////////////////////////////////////////////////////////////////////
    // address generation
    always_comb begin
        vHit = 1'b0;
        vPtr = 2'd0;
        vSlot = VS_VIRTUAL_INDIRECT_OPERAND;
        if (req.fullMode) begin
            directAddr = req.fullAddr;
        end else if (req.accessSel) begin
            // bank on top, opcode byte below
            directAddr = {st_reg.bank, req.fileAddr};
        end else if (st_reg.extCfg && req.fileAddr <= ILO_LIMIT) begin
            // offset from third pointer
            directAddr = st_reg.ptr[2] + {4'h0, req.fileAddr};
        end else if (req.fileAddr < ACC_SPLIT) begin
            directAddr = {ACC_LO_BANK, req.fileAddr};
        end else begin
            directAddr = {ACC_HI_BANK, req.fileAddr};
        end
        // find virtual operand slot
        for (int n = 0; n < NUM_PTR; n++) begin
            for (int k = 0; k <= 4; k++) begin
                if (directAddr == VIRT_BASE - 12'(n * VIRT_STRIDE + k)) begin
                    vHit = 1'b1;
                    vPtr = 2'(n);
                    vSlot = 3'(k);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pointer use and adjust, whole 12 bits at once
    always_comb begin
        curPtr = st_reg.ptr[vPtr];
        usePtr = curPtr;
        newPtr = curPtr;
        case (vSlot)
            VS_POST_INCREMENT_OPERAND: newPtr = curPtr + 12'h001;
            VS_POST_DECREMENT_OPERAND: newPtr = curPtr - 12'h001;
            VS_PRE_INCREMENT_OPERAND: begin
                usePtr = curPtr + 12'h001;
                newPtr = usePtr;
            end
            // signed working offset, nothing stored
            VS_INDEXED_BY_WORKING_OPERAND: usePtr = curPtr + {{4{req.work[7]}}, req.work};
            default: usePtr = curPtr; // plain virtual operand
        endcase
        // virtual operand has no storage of its own
        effAddr = vHit ? usePtr : directAddr;
    end

    ////////////////////////////////////////////////////////////////////
    // alu and its flags
    always_comb begin
        // subtract is add of two's complement
        cin = (req.op == OP_SUB);
        opB = cin ? ~req.work : req.work;
        sum9 = {1'b0, req.fileData} + {1'b0, opB} + {8'h00, cin};
        sum5 = {1'b0, req.fileData[3:0]} + {1'b0, opB[3:0]} + {4'h0, cin};
        aluRes = req.fileData;
        aluNew = st_reg.flags;
        aluMask = 5'h00;
        case (req.op)
            OP_ADD, OP_SUB: begin
                aluRes = sum9[7:0];
                aluMask = FLG_ALL;
                aluNew[FLG_C] = sum9[8];
                aluNew[FLG_DC] = sum5[4];
                // same signs in, other sign out
                aluNew[FLG_OV] = (req.fileData[7] == opB[7]) && (sum9[7] != req.fileData[7]);
            end
            OP_AND: begin
                aluRes = req.fileData & req.work;
                aluMask = 5'h14;
            end
            OP_OR: begin
                aluRes = req.fileData | req.work;
                aluMask = 5'h14;
            end
            OP_XOR: begin
                aluRes = req.fileData ^ req.work;
                aluMask = 5'h14;
            end
            OP_CLR: begin
                aluRes = 8'h00;
                aluMask = 5'h04;
            end
            OP_RLC: begin
                aluRes = {req.fileData[6:0], st_reg.flags[FLG_C]};
                aluMask = 5'h17;
                aluNew[FLG_C] = req.fileData[7];
                aluNew[FLG_DC] = req.fileData[3];
            end
            OP_RRC: begin
                aluRes = {st_reg.flags[FLG_C], req.fileData[7:1]};
                aluMask = 5'h17;
                aluNew[FLG_C] = req.fileData[0];
                aluNew[FLG_DC] = req.fileData[4];
            end
            default: aluRes = req.fileData; // move and jump
        endcase
        aluNew[FLG_N] = aluRes[7];
        aluNew[FLG_Z] = (aluRes == 8'h00);
        aluNew = (st_reg.flags & ~aluMask) | (aluNew & aluMask);
        // clear and full moves write the file
        fileWr = req.destSel || req.fullMode || req.op == OP_CLR;
    end

    ////////////////////////////////////////////////////////////////////
    // next state: apb first, core request overrides
    assign apbSetup = apbReq.psel && !apbReq.penable;
    assign apbWrite = apbReq.psel && apbReq.penable && apbReq.pwrite;

    always_comb begin
        st_next = st_reg;
        st_next.rsp.valid = 1'b0;
        // register writes on the access edge
        if (apbWrite && apbReq.pstrb[0]) begin
            case (apbReq.paddr)
                OFS_FLAGS: st_next.flags = apbReq.pwdata[4:0];
                OFS_BANK: st_next.bank = apbReq.pwdata[3:0];
                OFS_CFG: st_next.extCfg = apbReq.pwdata[0];
                default: st_next.extCfg = st_reg.extCfg;
            endcase
        end
        // pointer bytes, upper high nibble dropped
        for (int n = 0; n < NUM_PTR; n++) begin
            if (apbWrite && apbReq.paddr == OFS_PTR0 + 8'(n * 4)) begin
                if (apbReq.pstrb[0]) st_next.ptr[n][7:0] = apbReq.pwdata[7:0];
                if (apbReq.pstrb[1]) st_next.ptr[n][11:8] = apbReq.pwdata[11:8];
            end
        end
        // read data latched in setup
        if (apbSetup) begin
            st_next.prdata = 32'h0000_0000;
            st_next.slverr = 1'b0;
            case (apbReq.paddr)
                OFS_FLAGS: st_next.prdata[4:0] = st_reg.flags;
                OFS_BANK: st_next.prdata[3:0] = st_reg.bank;
                OFS_PTR0: st_next.prdata[11:0] = st_reg.ptr[0];
                OFS_PTR0 + OFS_STEP: st_next.prdata[11:0] = st_reg.ptr[1];
                OFS_PTR0 + 8'h08: st_next.prdata[11:0] = st_reg.ptr[2];
                OFS_CFG: st_next.prdata[0] = st_reg.extCfg;
                default: st_next.slverr = 1'b1; // unmapped
            endcase
        end
        // core request wins over a same-cycle apb write
        if (req.valid) begin
            st_next.rsp.valid = 1'b1;
            st_next.rsp.dataAddr = effAddr;
            st_next.rsp.result = aluRes;
            st_next.rsp.fileWrite = fileWr && req.op != OP_JUMP;
            st_next.rsp.workWrite = !fileWr && req.op != OP_JUMP;
            st_next.rsp.indirect = vHit;
            st_next.rsp.jumpTarget = (req.op == OP_JUMP) ? req.jumpLit : 20'h00000;
            if (vHit) begin
                st_next.ptr[vPtr] = newPtr;
            end
            if (aluMask != 5'h00) begin
                // alu flags beat the stored result
                st_next.flags = aluNew;
            end else if (fileWr && effAddr == FLAG_ADDR && req.op == OP_MOVE) begin
                st_next.flags = aluRes[4:0]; // plain move
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // single state register, sync reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs
    assign rsp = st_reg.rsp;
    assign flagsOut = {3'b000, st_reg.flags};
    assign apbRsp.prdata = st_reg.prdata;
    // zero-wait slave: ready in first access cycle
    assign apbRsp.pready = apbReq.psel && apbReq.penable;
    assign apbRsp.pslverr = apbReq.psel && apbReq.penable && st_reg.slverr;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    logic arith; // add or subtract request
    assign arith = req.valid && (req.op == OP_ADD || req.op == OP_SUB);

    property p_flag_dest;
        // stored flags must be the alu's, never the written byte
        arith && fileWr && effAddr == FLAG_ADDR |=> flagsOut[FLG_N] == rsp.result[7]
            && flagsOut[FLG_Z] == (rsp.result == 8'h00)
            && flagsOut[FLG_C] == (($past(req.op) == OP_ADD)
            ? ({1'b0, $past(req.fileData)} + {1'b0, $past(req.work)} > 9'h0ff)
            : ($past(req.fileData) >= $past(req.work)));
    endproperty
    a_flag_dest: assert property (p_flag_dest) else $error("flag dest write not masked");

    property p_clr_flag;
        req.valid && req.op == OP_CLR && effAddr == FLAG_ADDR |=> flagsOut == ($past(flagsOut) | 8'h04);
    endproperty
    a_clr_flag: assert property (p_clr_flag) else $error("clear of flags wrong");

    property p_neg;
        // clear touches zero only, so it leaves negative alone
        req.valid && req.op != OP_MOVE && req.op != OP_JUMP && req.op != OP_CLR
            |=> flagsOut[FLG_N] == rsp.result[7];
    endproperty
    a_neg: assert property (p_neg) else $error("negative flag wrong");

    property p_zero;
        req.valid && req.op != OP_MOVE && req.op != OP_JUMP |=> flagsOut[FLG_Z] == (rsp.result == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_add_carry;
        req.valid && req.op == OP_ADD
            |=> flagsOut[FLG_C] == ({1'b0, $past(req.fileData)} + {1'b0, $past(req.work)} > 9'h0ff)
            && flagsOut[FLG_DC] == ({1'b0, $past(req.fileData[3:0])} + {1'b0, $past(req.work[3:0])} > 5'h0f);
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

    property p_sub_borrow;
        req.valid && req.op == OP_SUB |=> flagsOut[FLG_C] == ($past(req.fileData) >= $past(req.work));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("borrow polarity wrong");

    property p_bank;
        req.valid && !req.fullMode && req.accessSel && !vHit |=> rsp.dataAddr == {$past(st_reg.bank), $past(req.fileAddr)};
    endproperty
    a_bank: assert property (p_bank) else $error("banked address wrong");

    property p_access;
        req.valid && !req.fullMode && !req.accessSel && req.fileAddr >= ACC_SPLIT && !vHit
            |=> rsp.dataAddr[11:8] == ACC_HI_BANK;
    endproperty
    a_access: assert property (p_access) else $error("access bank wrong");

    property p_post_increment_operand;
        // address and pointer always checked; flags only when the op leaves them
        req.valid && vHit && vSlot == VS_POST_INCREMENT_OPERAND |=> rsp.dataAddr == $past(curPtr)
            && st_reg.ptr[$past(vPtr)] == $past(curPtr) + 12'h001
            && ($past(aluMask) != 5'h00 || flagsOut == $past(flagsOut));
    endproperty
    a_post_increment_operand: assert property (p_post_increment_operand) else $error("post increment wrong");

    property p_indirect;
        req.valid && vHit && vSlot == VS_VIRTUAL_INDIRECT_OPERAND |=> rsp.dataAddr == $past(curPtr) && rsp.indirect;
    endproperty
    a_indirect: assert property (p_indirect) else $error("indirect address wrong");

    c_add_carry: cover property (req.valid && req.op == OP_ADD && sum9[8]);
    c_clr_flag: cover property (req.valid && req.op == OP_CLR && effAddr == FLAG_ADDR);
    c_roll: cover property (req.valid && vHit && vSlot == VS_POST_INCREMENT_OPERAND && curPtr[7:0] == 8'hff);
    c_indexed_by_working_operand: cover property (req.valid && vHit && vSlot == VS_INDEXED_BY_WORKING_OPERAND);
endmodule : afa_core
`default_nettype wire

// ### tb/afa_data_mem.sv
/*
 afa_data_mem: behavioural data memory on the far side of the core.
 assumes: the core's registered answer names the address and the byte to store.
*/
`timescale 1ns/1ps
`default_nettype none
module afa_data_mem
    import afa_pkg::*;
(
    input wire logic sys_clk, // core clock
    input wire afa_pkg::afa_rsp_t rsp, // core answer
    input wire logic [11:0] peekAddr, // bench probe address
    output logic [7:0] peekData // probed byte
);
    import afa_pkg::*;
    logic [7:0] mem [4096]; // whole linear data space
    ////////////////////////////////////////////////////////////////////////
    // non-zero fill so a missed clear shows up
    initial begin
        foreach (mem[i]) begin
            mem[i] = 8'haa;
        end
    end
    // only file writes land here; working-register results never do
    always @(posedge sys_clk) begin
        if (rsp.valid === 1'b1 && rsp.fileWrite === 1'b1) begin
            mem[rsp.dataAddr] <= rsp.result;
        end
    end
    assign peekData = mem[peekAddr];
endmodule : afa_data_mem
`default_nettype wire

// ### tb/afa_core_tb.sv
/*
 afa_core_tb: self-checking bench, queue of expected answers and a monitor.
 assumes: afa_pkg compiled first; data memory model beside the core.
*/
`timescale 1ns/1ps
`default_nettype none
module afa_core_tb;
    import afa_pkg::*;
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] res;
        logic [4:0] flags;
        logic fw, ww, ind, full;
        logic [19:0] jt;
    } afa_exp_t;
    logic sys_clk = 1'b0; // core clock
    logic sys_rst = 1'b1; // sync reset
    afa_req_t req = '0; // decoder side
    afa_rsp_t rsp;
    logic [7:0] flagsOut;
    afa_apb_req_t apbReq = '0; // register bus
    afa_apb_rsp_t apbRsp;
    logic [11:0] peekAddr = 12'h3a5;
    logic [7:0] peekData;
    afa_exp_t expQ [$]; // pending answers
    afa_exp_t monE, e;
    afa_req_t r;
    int fails = 0;
    int tests_run = 0;
    int seed = 13723;
    int i;
    logic [4:0] expFlags = 5'h00; // flags as the bench predicts them
    logic [3:0] bank = 4'h0;
    logic [31:0] rd;
    logic er;
    afa_op_t opTab [7] = '{OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_RLC, OP_RRC};
    afa_op_t edgeOp [4] = '{OP_ADD, OP_SUB, OP_ADD, OP_SUB};
    logic [7:0] edgeA [4] = '{8'h7f, 8'h00, 8'hff, 8'h80};
    logic [7:0] edgeB [4] = '{8'h01, 8'h01, 8'h01, 8'h01};
    // slot byte, working value, pointer address expected
    logic [7:0] slotFa [8] = '{8'hee, 8'hef, 8'hed, 8'hef, 8'he4, 8'he7, 8'hdb, 8'hdf};
    logic [7:0] slotWk [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hfe, 8'h00};
    logic [11:0] slotAd [8] = '{12'h0ff, 12'h100, 12'h100, 12'h0ff, 12'h300, 12'h300, 12'h00e, 12'h010};

    afa_core afa_core_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req), .rsp(rsp), .flagsOut(flagsOut),
        .apbReq(apbReq), .apbRsp(apbRsp));
    afa_data_mem afa_data_mem_i (.sys_clk(sys_clk), .rsp(rsp), .peekAddr(peekAddr), .peekData(peekData));

    ////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    // reference arithmetic, written apart from the design
    function automatic afa_exp_t model(input afa_req_t q, input logic [4:0] f, input logic [3:0] bk);
        afa_exp_t x;
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] b;
        x = '0;
        x.flags = f;
        x.full = 1'b1;
        b = (q.op == OP_SUB) ? ~q.work : q.work; // subtract adds the complement
        s = {1'b0, q.fileData} + {1'b0, b} + 9'(q.op == OP_SUB);
        h = {1'b0, q.fileData[3:0]} + {1'b0, b[3:0]} + 5'(q.op == OP_SUB);
        x.addr = q.fullMode ? q.fullAddr : q.accessSel ? {bk, q.fileAddr}
            : {(q.fileAddr < 8'h60) ? 4'h0 : 4'hf, q.fileAddr};
        x.fw = q.destSel | q.fullMode | (q.op == OP_CLR);
        x.ww = ~x.fw;
        case (q.op)
            OP_ADD, OP_SUB: begin
                x.res = s[7:0];
                x.flags[FLG_C] = s[8];
                x.flags[FLG_DC] = h[4];
                x.flags[FLG_OV] = (q.fileData[7] == b[7]) && (s[7] != b[7]);
            end
            OP_AND: x.res = q.fileData & q.work;
            OP_OR: x.res = q.fileData | q.work;
            OP_XOR: x.res = q.fileData ^ q.work;
            OP_RLC: begin
                x.res = {q.fileData[6:0], f[FLG_C]};
                x.flags[FLG_C] = q.fileData[7];
                x.flags[FLG_DC] = q.fileData[3];
            end
            OP_RRC: begin
                x.res = {f[FLG_C], q.fileData[7:1]};
                x.flags[FLG_C] = q.fileData[0];
                x.flags[FLG_DC] = q.fileData[4];
            end
            OP_JUMP: begin
                x = '0;
                x.flags = f;
                x.jt = q.jumpLit;
            end
            default: x.res = (q.op == OP_CLR) ? 8'h00 : q.fileData; // move passes the operand through
        endcase
        if (q.op == OP_CLR) begin
            x.flags[FLG_Z] = 1'b1;
        end else if (q.op != OP_MOVE && q.op != OP_JUMP) begin
            x.flags[FLG_N] = x.res[7];
            x.flags[FLG_Z] = x.res == 8'h00;
        end
        // a plain move into the flag register stores the low five bits
        if (q.op == OP_MOVE && x.fw && x.addr == FLAG_ADDR) begin
            x.flags = q.fileData[4:0];
        end
        return x;
    endfunction : model

    task chk(input bit ok);
        tests_run++;
        if (!ok) begin
            fails++;
            $display("[ERR] %0t value mismatch", $time);
        end
    endtask : chk

    // one request per call; caller leaves valid up for back to back
    task send(input afa_req_t q, input afa_exp_t x);
        @(posedge sys_clk);
        q.valid = 1'b1;
        req <= q;
        expQ.push_back(x);
        expFlags = x.flags;
    endtask : send

    task idle();
        @(posedge sys_clk);
        req.valid <= 1'b0;
    endtask : idle

    // apb master: setup, access until pready, then release
    task apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rdv,
        output logic erv);
        int n;
        @(posedge sys_clk);
        apbReq.psel <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite <= wr;
        apbReq.paddr <= ad;
        apbReq.pwdata <= wd;
        apbReq.pstrb <= 4'hf;
        @(posedge sys_clk);
        apbReq.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (apbRsp.pready !== 1'b1 && n < 50);
        chk(n < 50);
        rdv = apbRsp.prdata;
        erv = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask : apb

    task give_verdict();
        if (fails == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////
    // monitor: oldest note against every answer pulse
    always @(posedge sys_clk) begin
        if (rsp.valid === 1'b1) begin
            if (expQ.size() == 0) begin
                fails++;
                $display("[ERR] %0t unexpected answer", $time);
            end else begin
                monE = expQ.pop_front();
                tests_run++;
                if ((monE.full && (rsp.dataAddr !== monE.addr || rsp.result !== monE.res))
                    || flagsOut !== {3'h0, monE.flags} || rsp.fileWrite !== monE.fw
                    || rsp.workWrite !== monE.ww || rsp.indirect !== monE.ind
                    || rsp.jumpTarget !== monE.jt) begin
                    fails++;
                    $display("[ERR] %0t answer mismatch", $time);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        chk(flagsOut === 8'h00);
        apb(1'b1, OFS_BANK, 32'h5, rd, er);
        bank = 4'h5;
        // random alu traffic, direct addressing, boundary operands first
        for (i = 0; i < 60; i++) begin
            r = '0;
            r.op = opTab[i % 7];
            r.fileData = 8'($random(seed));
            r.work = 8'($random(seed));
            r.fileAddr = 8'($random(seed)) & 8'hbf;
            r.accessSel = 1'($random(seed));
            r.destSel = 1'($random(seed));
            if (i < 4) begin
                r.op = edgeOp[i];
                r.fileData = edgeA[i];
                r.work = edgeB[i];
            end
            if (i == 30) begin
                idle();
                apb(1'b1, OFS_BANK, 32'ha, rd, er);
                bank = 4'ha;
            end
            send(r, model(r, expFlags, bank));
        end
        // full address, then alu and clear aimed at the flag register
        r = '0;
        r.op = OP_CLR;
        r.fullMode = 1'b1;
        r.fullAddr = 12'h3a5;
        send(r, model(r, expFlags, bank));
        r.op = OP_ADD;
        r.fullAddr = FLAG_ADDR;
        r.fileData = 8'h90;
        r.work = 8'h90;
        send(r, model(r, expFlags, bank));
        r.op = OP_CLR;
        send(r, model(r, expFlags, bank));
        r.op = OP_MOVE;
        r.fileData = 8'h35;
        send(r, model(r, expFlags, bank));
        r = '0;
        r.op = OP_JUMP;
        r.jumpLit = 20'($random(seed));
        send(r, model(r, expFlags, bank));
        idle();
        // pointers, then every virtual slot kind back to back
        apb(1'b1, OFS_PTR0, 32'h0ff, rd, er);
        apb(1'b1, OFS_PTR0 + OFS_STEP, 32'h2ff, rd, er);
        apb(1'b1, OFS_PTR0 + 8'h08, 32'h010, rd, er);
        for (i = 0; i < 8; i++) begin
            r = '0;
            r.op = OP_MOVE;
            r.fileAddr = slotFa[i];
            r.work = slotWk[i];
            e = model(r, expFlags, bank);
            e.addr = slotAd[i];
            e.ind = 1'b1;
            send(r, e);
            chk(rsp.valid !== 1'b1 || rsp.fileWrite === 1'b0);
        end
        idle();
        apb(1'b0, OFS_PTR0, 32'h0, rd, er);
        chk(rd === 32'h0ff && er === 1'b0);
        apb(1'b0, OFS_PTR0 + OFS_STEP, 32'h0, rd, er);
        chk(rd === 32'h300);
        chk(peekData === 8'h00);
        // extended set: literal offset from pointer 2 only when enabled
        apb(1'b1, OFS_PTR0 + 8'h08, 32'h123, rd, er);
        apb(1'b1, OFS_CFG, 32'h1, rd, er);
        for (i = 0; i < 3; i++) begin
            if (i == 2) begin
                idle();
                apb(1'b1, OFS_CFG, 32'h0, rd, er);
            end
            r = '0;
            r.op = OP_ADD;
            r.fileData = 8'($random(seed));
            r.fileAddr = (i == 1) ? 8'h60 : 8'h10;
            e = model(r, expFlags, bank);
            if (i == 0) begin
                e.addr = 12'h133;
            end
            send(r, e);
        end
        idle();
        apb(1'b0, 8'h40, 32'h0, rd, er);
        chk(er === 1'b1 && rd === 32'h0);
        apb(1'b0, OFS_BANK, 32'h0, rd, er);
        chk(rd === 32'ha && er === 1'b0);
        for (i = 0; i < 20 && expQ.size() > 0; i++) begin
            @(posedge sys_clk);
        end
        if (expQ.size() > 0) begin
            fails++;
            $display("[ERR] %0t answers missing", $time);
        end
        give_verdict();
    end
endmodule : afa_core_tb
`default_nettype wire
